// ### verilog/tch_top.sv
// Tachometer control core: switch setup, run/function modes, hold, comparison output
// How it works
// - Switch 2 picks counting rate: off is 30 Hz, on is 10 kHz.
// - Switches 3 and 4 pick output mode: band, area, upper, lower limit.
// - Switches 5 and 6 pick averaging: none, 2, 4 or 8 samples.
// - Switch 8 picks sinking or sourcing inputs for all external inputs.
// - Switches are read once at power-up; later changes wait for power-on.
// - Function-setting mode keeps measuring and driving output with old settings.
// - Edited settings take effect only on returning to run mode.
// - A changed setting resets counter on return: values cleared, output off.
// - Hold freezes the displayed value and the control output; only a return with a changed setting clears them.
// - Hold indicator lights for external hold or the hold key.
// - Three separate hold terminals, each alone requests hold.
// - Key-protection indicator follows the key-protect switch.
// - Output indicator lights exactly while the control output is on.
// - Output follows comparison of measurement against limits per output mode.
// - Mode key steps between modes and setting items.
// - One result per averaging period: 200 ms times averaging count.
// - Low rate filters contact bounce on the count input.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`include "tch_map.svh"
module tch_top #(
  parameter int W            = 24,
  parameter int NUM_ITEMS    = 2,
  parameter int SAMPLE_CYC   = `TCH_SAMPLE_CYC,
  parameter int DEBOUNCE_CYC = `TCH_DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Field inputs
  input  wire logic        count_in,
  input  wire logic [2:0]  hold_in,
  // Front panel
  input  wire logic        hold_key,
  input  wire logic        mode_key,
  input  wire logic        kprot_sw,
  input  wire logic [8:1]  dip_sw,
  // Output and indicators
  output logic             ctrl_out,
  output logic             ind_hold,
  output logic             ind_kprot,
  output logic             ind_out
);
  import tch_pkg::*;

  localparam int NP = 15;

  typedef struct packed {
    tch_state_e   state;
    logic [1:0]   item;
    logic [1:0]   boot;
    tch_cfg_s     cfg;
    logic [W-1:0] cmp1_act;
    logic [W-1:0] cmp2_act;
    logic [W-1:0] cmp1_ed;
    logic [W-1:0] cmp2_ed;
    logic         changed;
    logic         mode_prev;
    logic [W-1:0] disp;
    logic         out;
    logic         ack;
    logic [31:0]  rdata;
  } tch_top_s;

  tch_top_s     r_ff;
  tch_top_s     nxt_r;
  logic         rst_n;
  logic [NP-1:0] pin_s;
  logic [8:1]   dip_s;
  logic [2:0]   hold_s;
  logic         cnt_s;
  logic         hkey_s;
  logic         mode_s;
  logic         kprot_s;
  logic         running;
  logic         ext_hold;
  logic         hold_act;
  logic         mode_rise;
  logic         ret;
  logic         ret_clr;
  logic         bus_req;
  logic [31:0]  rd_mux;
  tch_cfg_s     dip_cfg;

  tch_meas_if #(.W(W)) mif ();

  // Reset release through two flops, asserted at once
  tch_sync #(.W(1)) u_rst (
    .clk   (mclk),
    .rst_b (rst_b),
    .d     (1'b1),
    .q     (rst_n)
  );

  // Every pin is asynchronous to mclk
  tch_sync #(.W(NP)) u_pins (
    .clk   (mclk),
    .rst_b (rst_n),
    .d     ({dip_sw, kprot_sw, mode_key, hold_key, hold_in, count_in}),
    .q     (pin_s)
  );

  tch_meas #(.W(W), .SAMPLE_CYC(SAMPLE_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) u_meas (
    .mclk  (mclk),
    .rst_n (rst_n),
    .m     (mif.mt)
  );

  // Unpack synchronised pins
  assign cnt_s   = pin_s[0];
  assign hold_s  = pin_s[3:1];
  assign hkey_s  = pin_s[4];
  assign mode_s  = pin_s[5];
  assign kprot_s = pin_s[6];
  assign dip_s   = pin_s[14:7];

  // Switch decode; positions 1 and 7 are never looked at
  assign dip_cfg.rate_hi  = dip_s[`TCH_SW_RATE];
  assign dip_cfg.omode    = tch_omode_e'({dip_s[`TCH_SW_OM_B], dip_s[`TCH_SW_OM_A]});
  assign dip_cfg.avg_log2 = {dip_s[`TCH_SW_AVG_B], dip_s[`TCH_SW_AVG_A]};
  assign dip_cfg.pol_src  = dip_s[`TCH_SW_POL];

  // Polarity applies to all external inputs; hold terminals, hold key and count input act only once setup is read
  assign running  = (r_ff.state != TCH_ST_BOOT);
  assign ext_hold = running && (|(hold_s ^ {3{~r_ff.cfg.pol_src}}));
  assign hold_act = ext_hold || (running && hkey_s);

  // Mode key stepping and the return to run mode
  assign mode_rise = mode_s && !r_ff.mode_prev;
  assign ret       = (r_ff.state == TCH_ST_FUNC) && mode_rise && (r_ff.item == 2'(NUM_ITEMS - 1));
  assign ret_clr   = ret && r_ff.changed;

  // Measurement engine steering
  assign mif.cnt_lvl  = running && (cnt_s ^ ~r_ff.cfg.pol_src);
  assign mif.low_rate = ~r_ff.cfg.rate_hi;
  assign mif.avg_log2 = r_ff.cfg.avg_log2;
  assign mif.clr      = ret_clr;

  // Bus answers one cycle after the request appears
  assign bus_req = avs_read || avs_write;

  // Comparison against the active limits; value 1 is upper (lower in lower-limit mode), value 2 lower
  function automatic logic cmp_out(tch_omode_e om, logic [W-1:0] v, logic [W-1:0] c1, logic [W-1:0] c2);
    case (om)
      TCH_OM_HILO: cmp_out = (v >= c1) || (v <= c2);
      TCH_OM_AREA: cmp_out = (v <= c1) && (v >= c2);
      TCH_OM_HI:   cmp_out = (v >= c1);
      TCH_OM_LO:   cmp_out = (v <= c1);
      default:     cmp_out = 1'b0;
    endcase
  endfunction : cmp_out

  // Byte-lane merge of a write into a limit
  function automatic logic [W-1:0] merge(logic [W-1:0] old, logic [31:0] wd, logic [3:0] be);
    merge = old;
    for (int i = 0; i < W; i++) begin
      if (be[i / 8]) begin
        merge[i] = wd[i];
      end
    end
  endfunction : merge

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (avs_address)
      `TCH_OFS_CFG:  rd_mux = 32'(r_ff.cfg);
      `TCH_OFS_CMP1: rd_mux = 32'((r_ff.state == TCH_ST_FUNC) ? r_ff.cmp1_ed : r_ff.cmp1_act);
      `TCH_OFS_CMP2: rd_mux = 32'((r_ff.state == TCH_ST_FUNC) ? r_ff.cmp2_ed : r_ff.cmp2_act);
      `TCH_OFS_STAT: rd_mux = 32'({kprot_s, hold_act, r_ff.out, r_ff.changed, r_ff.item, r_ff.state});
      `TCH_OFS_MEAS: rd_mux = 32'(r_ff.disp);
      default:       rd_mux = 32'h00000000;
    endcase
  end

  // Next state of the whole core
  always_comb begin
    nxt_r           = r_ff;
    nxt_r.mode_prev = mode_s;
    nxt_r.ack       = bus_req && !r_ff.ack;
    if (bus_req && !r_ff.ack) begin
      nxt_r.rdata = rd_mux;
    end
    case (r_ff.state)
      TCH_ST_BOOT: begin
        // Wait until the pin synchroniser holds real values, then latch once
        nxt_r.boot = r_ff.boot + 2'h1;
        if (r_ff.boot == `TCH_BOOT_WAIT) begin
          nxt_r.cfg   = dip_cfg;
          nxt_r.state = TCH_ST_RUN;
        end
      end
      TCH_ST_RUN: begin
        if (mode_rise) begin
          nxt_r.state   = TCH_ST_FUNC;
          nxt_r.item    = 2'h0;
          nxt_r.cmp1_ed = r_ff.cmp1_act;
          nxt_r.cmp2_ed = r_ff.cmp2_act;
          nxt_r.changed = 1'b0;
        end
      end
      TCH_ST_FUNC: begin
        if (mode_rise && !ret) begin
          nxt_r.item = r_ff.item + 2'h1;
        end
      end
      default: nxt_r.state = TCH_ST_BOOT;
    endcase
    // Edits land in the shadow copies only; a write racing the return is dropped
    if (r_ff.ack && avs_write && (r_ff.state == TCH_ST_FUNC) && !ret) begin
      if (avs_address == `TCH_OFS_CMP1) begin
        nxt_r.cmp1_ed = merge(r_ff.cmp1_ed, avs_writedata, avs_byteenable);
      end
      if (avs_address == `TCH_OFS_CMP2) begin
        nxt_r.cmp2_ed = merge(r_ff.cmp2_ed, avs_writedata, avs_byteenable);
      end
      if ((nxt_r.cmp1_ed != r_ff.cmp1_ed) || (nxt_r.cmp2_ed != r_ff.cmp2_ed)) begin
        nxt_r.changed = 1'b1;
      end
    end
    // New result updates display and output unless held, in either mode
    if (mif.valid && !hold_act) begin
      nxt_r.disp = mif.value;
      nxt_r.out  = cmp_out(r_ff.cfg.omode, mif.value, r_ff.cmp1_act, r_ff.cmp2_act);
    end
    // Return applies edits; a change restarts the counter and drops the output
    if (ret) begin
      nxt_r.state    = TCH_ST_RUN;
      nxt_r.cmp1_act = r_ff.cmp1_ed;
      nxt_r.cmp2_act = r_ff.cmp2_ed;
    end
    if (ret_clr) begin
      nxt_r.disp = '0;
      nxt_r.out  = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs
  assign avs_readdata    = r_ff.rdata;
  assign avs_waitrequest = bus_req && !r_ff.ack;
  assign ctrl_out        = r_ff.out;
  assign ind_out         = r_ff.out;
  assign ind_hold        = hold_act;
  assign ind_kprot       = kprot_s;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_CFG_FROZEN: assert property (running |=> $stable(r_ff.cfg))
    else $error("switch setup changed while powered");
  AST_EDIT_DEFERRED: assert property ((r_ff.state == TCH_ST_FUNC) && !ret |=>
    $stable(r_ff.cmp1_act) && $stable(r_ff.cmp2_act))
    else $error("limits changed before return to run");
  AST_CLEAR_ON_RETURN: assert property (ret_clr |=> !ctrl_out && (r_ff.disp == '0) &&
    (r_ff.state == TCH_ST_RUN))
    else $error("counter not reset after changed setting");
  AST_HOLD_FREEZE: assert property (hold_act && !ret_clr |=> $stable(ctrl_out) && $stable(r_ff.disp))
    else $error("held output or value moved");
  AST_MEAS_IN_FUNC: assert property ((r_ff.state == TCH_ST_FUNC) && mif.valid && !hold_act && !ret_clr
    |=> r_ff.disp == $past(mif.value))
    else $error("measurement stopped in function mode");
  AST_HOLD_TERMINAL: assert property (running && (hold_s[2] == r_ff.cfg.pol_src) |-> ind_hold)
    else $error("single hold terminal ignored");
  AST_OUT_LED: assert property (ind_out == ctrl_out)
    else $error("output indicator mismatch");
  AST_KPROT_LED: assert property ($rose(kprot_sw) ##2 kprot_sw |-> ind_kprot)
    else $error("key-protect indicator not lit");
  AST_CMP_HI: assert property (mif.valid && !hold_act && !ret_clr && (r_ff.cfg.omode == TCH_OM_HI)
    |=> ctrl_out == ($past(mif.value) >= $past(r_ff.cmp1_act)))
    else $error("upper-limit comparison wrong");
  AST_MODE_STEP: assert property ((r_ff.state == TCH_ST_RUN) && mode_rise |=>
    (r_ff.state == TCH_ST_FUNC) && (r_ff.item == 2'h0))
    else $error("mode key did not enter function mode");
  AST_BUS_ANSWER: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  COV_ENTER_FUNC: cover property ((r_ff.state == TCH_ST_RUN) && mode_rise);
  COV_CLEAR: cover property (ret_clr);
  COV_HOLD_RESULT: cover property (hold_act && mif.valid);
endmodule : tch_top

// ### shared/tch_map.svh
// Constants of the tachometer control core: offsets, switch positions, timing
`ifndef TCH_MAP_SVH
`define TCH_MAP_SVH

// Clock and timing
`define TCH_CLK_HZ        100000000
`define TCH_SAMPLE_MS     200
`define TCH_DEBOUNCE_MS   5
`define TCH_SAMPLE_CYC    (`TCH_SAMPLE_MS * (`TCH_CLK_HZ / 1000))
`define TCH_DEBOUNCE_CYC  (`TCH_DEBOUNCE_MS * (`TCH_CLK_HZ / 1000))
`define TCH_HZ_PER_CNT    (1000 / `TCH_SAMPLE_MS)
`define TCH_BOOT_WAIT     2'h3

// Register byte offsets
`define TCH_OFS_CFG       5'h00
`define TCH_OFS_CMP1      5'h04
`define TCH_OFS_CMP2      5'h08
`define TCH_OFS_STAT      5'h0C
`define TCH_OFS_MEAS      5'h10

// Configuration switch positions
`define TCH_SW_RATE       2
`define TCH_SW_OM_A       3
`define TCH_SW_OM_B       4
`define TCH_SW_AVG_A      5
`define TCH_SW_AVG_B      6
`define TCH_SW_POL        8

`endif

// ### shared/tch_pkg.sv
// Types shared by the tachometer control core
package tch_pkg;

  // Operating state, gray along boot -> run -> function setting
  typedef enum logic [1:0] {
    TCH_ST_BOOT = 2'b00,
    TCH_ST_RUN  = 2'b01,
    TCH_ST_FUNC = 2'b11
  } tch_state_e;

  // Output mode, encoded as {switch 4, switch 3}
  typedef enum logic [1:0] {
    TCH_OM_HILO = 2'b00,
    TCH_OM_AREA = 2'b01,
    TCH_OM_HI   = 2'b10,
    TCH_OM_LO   = 2'b11
  } tch_omode_e;

  // Settings taken from the switches at power-up
  typedef struct packed {
    logic       rate_hi;
    tch_omode_e omode;
    logic [1:0] avg_log2;
    logic       pol_src;
  } tch_cfg_s;

endpackage : tch_pkg

// ### shared/tch_meas_if.sv
// Link between the control core and its measurement engine
`timescale 1ns/1ps
interface tch_meas_if #(parameter int W = 24);
  logic         cnt_lvl;
  logic         low_rate;
  logic         clr;
  logic [1:0]   avg_log2;
  logic         valid;
  logic [W-1:0] value;

  modport ctl (output cnt_lvl, output low_rate, output clr, output avg_log2, input valid, input value);
  modport mt  (input cnt_lvl, input low_rate, input clr, input avg_log2, output valid, output value);
endinterface : tch_meas_if

// ### verilog/tch_sync.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module tch_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Levels
  input  wire logic [W-1:0] d,
  output wire logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } tch_sync_s;

  tch_sync_s r_ff;
  tch_sync_s nxt_r;

  // First stage feeds only the second stage
  always_comb begin
    nxt_r.s1 = d;
    nxt_r.s2 = r_ff.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign q = r_ff.s2;
endmodule : tch_sync

// ### verilog/tch_meas.sv
// Measurement engine: debounce, 200 ms pulse windows, simple averaging
`timescale 1ns/1ps
`include "tch_map.svh"
module tch_meas #(
  parameter int W            = 24,
  parameter int SAMPLE_CYC   = `TCH_SAMPLE_CYC,
  parameter int DEBOUNCE_CYC = `TCH_DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Link to the control core
  tch_meas_if.mt    m
);
  import tch_pkg::*;

  localparam int WW = $clog2(SAMPLE_CYC + 1);
  localparam int DW = $clog2(DEBOUNCE_CYC + 1);

  typedef struct packed {
    logic         db_lvl;
    logic [DW-1:0] db_cnt;
    logic         prev;
    logic [WW-1:0] win;
    logic [W-1:0] pcnt;
    logic [W+2:0] acc;
    logic [2:0]   nsamp;
    logic         valid;
    logic [W-1:0] value;
  } tch_meas_s;

  tch_meas_s    r_ff;
  tch_meas_s    nxt_r;
  logic [W-1:0] sample;
  logic [W+2:0] sum;

  // Rate of one window in Hz and the running sum including it
  assign sample = W'(r_ff.pcnt * W'(`TCH_HZ_PER_CNT));
  assign sum    = r_ff.acc + (W+3)'(sample);

  always_comb begin
    nxt_r       = r_ff;
    nxt_r.valid = 1'b0;
    // Contacts bounce, so at the low rate a level must stand for the whole filter time
    if (!m.low_rate) begin
      nxt_r.db_lvl = m.cnt_lvl;
      nxt_r.db_cnt = '0;
    end else if (m.cnt_lvl == r_ff.db_lvl) begin
      nxt_r.db_cnt = '0;
    end else if (r_ff.db_cnt == DW'(DEBOUNCE_CYC - 1)) begin
      nxt_r.db_lvl = m.cnt_lvl;
      nxt_r.db_cnt = '0;
    end else begin
      nxt_r.db_cnt = r_ff.db_cnt + DW'(1);
    end
    // Count rising edges of the filtered level
    nxt_r.prev = r_ff.db_lvl;
    if (r_ff.db_lvl && !r_ff.prev) begin
      nxt_r.pcnt = r_ff.pcnt + W'(1);
    end
    // Window end: fold the sample into the average
    if (r_ff.win == WW'(SAMPLE_CYC - 1)) begin
      nxt_r.win  = '0;
      nxt_r.pcnt = W'(r_ff.db_lvl && !r_ff.prev);
      if (r_ff.nsamp == 3'((1 << m.avg_log2) - 1)) begin
        nxt_r.value = W'(sum >> m.avg_log2);
        nxt_r.valid = 1'b1;
        nxt_r.acc   = '0;
        nxt_r.nsamp = '0;
      end else begin
        nxt_r.acc   = sum;
        nxt_r.nsamp = r_ff.nsamp + 3'h1;
      end
    end else begin
      nxt_r.win = r_ff.win + WW'(1);
    end
    // Counter reset drops every partial measurement
    if (m.clr) begin
      nxt_r.win   = '0;
      nxt_r.pcnt  = '0;
      nxt_r.acc   = '0;
      nxt_r.nsamp = '0;
      nxt_r.value = '0;
      nxt_r.valid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign m.valid = r_ff.valid;
  assign m.value = r_ff.value;

  // A result comes only at a window boundary
  AST_VALID_AT_WINDOW: assert property (@(posedge mclk) disable iff (!rst_n)
    r_ff.valid |-> $past(r_ff.win) == WW'(SAMPLE_CYC - 1))
    else $error("result outside a window boundary");
endmodule : tch_meas

// ### tb/tch_src.sv
// Pulse sensor and hold contacts that drive the tachometer field pins
`timescale 1ns/1ps
module tch_src (
  // Clock
  input  wire logic       mclk,
  // Control from the bench
  input  wire logic       pol_src,
  input  wire logic [7:0] period,
  input  wire logic [2:0] hold_req,
  // Field pins
  output logic            count_in,
  output logic [2:0]      hold_in
);
  logic [7:0] ph_ff;

  // Free-running phase; a zero period parks the pin at its idle level
  always_ff @(posedge mclk) begin
    if (period == 8'h00 || ph_ff >= period - 8'h01)
      ph_ff <= 8'h00;
    else
      ph_ff <= ph_ff + 8'h01;
  end

  // Active level follows the polarity switch, idle is its inverse
  assign count_in = (period != 8'h00 && ph_ff < (period >> 1)) ? pol_src : ~pol_src;
  // Each terminal is driven on its own, so a stuck pair would show
  assign hold_in  = hold_req ~^ {3{pol_src}};
endmodule : tch_src

// ### tb/tch_top_bench.sv
// Self-checking bench of the tachometer control core
`timescale 1ns/1ps
`include "tch_map.svh"
module tch_top_bench;
  import tch_pkg::*;
  localparam int LIMIT = 30000;
  logic        mclk;
  logic        rst_b;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        count_in;
  logic [2:0]  hold_in;
  logic [2:0]  hold_req;
  logic [7:0]  period;
  logic        hold_key;
  logic        mode_key;
  logic        kprot_sw;
  logic [8:1]  dip_sw;
  logic        ctrl_out;
  logic        ind_hold;
  logic        ind_kprot;
  logic        ind_out;
  int          n_errors;
  int          num_checks;
  int          cyc;

  tch_top #(.W(24), .NUM_ITEMS(2), .SAMPLE_CYC(100), .DEBOUNCE_CYC(4)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .count_in(count_in),
    .hold_in(hold_in), .hold_key(hold_key), .mode_key(mode_key), .kprot_sw(kprot_sw),
    .dip_sw(dip_sw), .ctrl_out(ctrl_out), .ind_hold(ind_hold), .ind_kprot(ind_kprot),
    .ind_out(ind_out));

  tch_src i_src (.mclk(mclk), .pol_src(dip_sw[8]), .period(period), .hold_req(hold_req),
    .count_in(count_in), .hold_in(hold_in));

  // Clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Hang guard: counts as a mismatch and closes the run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus read: request held until waitrequest is seen low at an edge
  task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : av_rd

  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_write <= 1'b0;
  endtask : av_wr

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    av_rd(a, d);
    chk(d, exp);
  endtask : rd_chk

  // Reset with a switch setting, then poll until the core reaches run
  task automatic do_reset(input logic [8:1] sw);
    logic [31:0] st;
    st = 32'h0;
    rst_b  <= 1'b0;
    dip_sw <= sw;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 20 && st[1:0] !== 2'b01; i++) av_rd(`TCH_OFS_STAT, st);
    chk(st & 32'h3, 32'h1);
  endtask : do_reset

  // One mode key stroke, long enough to clear the synchroniser
  task automatic press();
    @(posedge mclk);
    mode_key <= 1'b1;
    repeat (4) @(posedge mclk);
    mode_key <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : press

  // Four switch codes, each setting switch seen both ways, with switches 1 and 7 toggled against the rest
  task automatic t_cfg();
    logic [1:0]  b;
    logic [8:1]  sw;
    logic [31:0] exp;
    for (int i = 0; i < 4; i++) begin
      b   = i[1:0];
      sw  = {b[1], ~b[0], b[1], b[0], b[0], b[1], b[0], ~b[1]};
      exp = {26'h0, b[0], b[0], b[1], b[1], b[0], b[1]};
      do_reset(sw);
      rd_chk(`TCH_OFS_CFG, exp);
      dip_sw <= ~sw;
      repeat (5) @(posedge mclk);
      rd_chk(`TCH_OFS_CFG, exp);
    end
  endtask : t_cfg

  // Edit the single limit; old settings must rule until the return to run
  task automatic edit_cmp1(input logic [23:0] v, input logic out_now);
    logic [31:0] d;
    press();
    av_rd(`TCH_OFS_STAT, d);
    chk(d & 32'hF, 32'h3);
    av_wr(`TCH_OFS_CMP1, {8'h0, v});
    rd_chk(`TCH_OFS_CMP1, {8'h0, v});
    repeat (300) @(posedge mclk);
    chk({31'h0, ctrl_out}, {31'h0, out_now});
    rd_chk(`TCH_OFS_MEAS, 32'h32);
    press();
    av_rd(`TCH_OFS_STAT, d);
    chk(d & 32'hF, 32'h7);
    press();
    av_rd(`TCH_OFS_STAT, d);
    chk(d & 32'h3, 32'h1);
    chk({31'h0, ctrl_out}, 32'h0);
    rd_chk(`TCH_OFS_MEAS, 32'h0);
    repeat (600) @(posedge mclk);
    rd_chk(`TCH_OFS_MEAS, 32'h32);
  endtask : edit_cmp1

  // Each hold terminal and the key in turn; pulses stop meanwhile
  task automatic t_hold();
    for (int k = 0; k < 4; k++) begin
      if (k < 3)
        hold_req[k] <= 1'b1;
      else
        hold_key <= 1'b1;
      period <= 8'h00;
      repeat (5) @(posedge mclk);
      chk({31'h0, ind_hold}, 32'h1);
      repeat (400) @(posedge mclk);
      rd_chk(`TCH_OFS_MEAS, 32'h32);
      chk({31'h0, ctrl_out}, 32'h1);
      hold_req <= 3'h0;
      hold_key <= 1'b0;
      period   <= 8'h0A;
      repeat (500) @(posedge mclk);
      chk({31'h0, ind_hold}, 32'h0);
    end
  endtask : t_hold

  // Key-protect indicator tracks its switch both ways
  task automatic t_kprot();
    logic [31:0] d;
    kprot_sw <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({31'h0, ind_kprot}, 32'h1);
    av_rd(`TCH_OFS_STAT, d);
    chk(d & 32'h80, 32'h80);
    kprot_sw <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({31'h0, ind_kprot}, 32'h0);
  endtask : t_kprot

  // One output mode at high rate, 2-sample average, sinking inputs; 10 pulses a window read as 50 Hz
  task automatic t_mode(input logic [8:1] sw, input logic [23:0] c1, input logic [23:0] c2, input logic exp);
    do_reset(sw);
    period <= 8'h0A;
    press();
    av_wr(`TCH_OFS_CMP1, {8'h0, c1});
    av_wr(`TCH_OFS_CMP2, {8'h0, c2});
    press();
    press();
    repeat (600) @(posedge mclk);
    chk({31'h0, ctrl_out}, {31'h0, exp});
  endtask : t_mode

  // Low rate: slow pulses pass the bounce filter, short ones are taken for chatter
  task automatic t_rate();
    do_reset(8'h10);
    period <= 8'h0A;
    repeat (600) @(posedge mclk);
    rd_chk(`TCH_OFS_MEAS, 32'h32);
    period <= 8'h06;
    repeat (600) @(posedge mclk);
    rd_chk(`TCH_OFS_MEAS, 32'h0);
  endtask : t_rate

  // Main sequence; setup after the switch test is high rate, upper limit, 2-sample average, sinking inputs
  initial begin
    rst_b = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    hold_req = 3'h0;
    period = 8'h00;
    hold_key = 1'b0;
    mode_key = 1'b0;
    kprot_sw = 1'b0;
    dip_sw = 8'h00;
    t_cfg();
    do_reset(8'h1A);
    period <= 8'h0A;
    repeat (600) @(posedge mclk);
    rd_chk(`TCH_OFS_MEAS, 32'h32);
    chk({31'h0, ctrl_out}, 32'h1);
    chk({31'h0, ind_out}, 32'h1);
    av_wr(`TCH_OFS_CMP1, 32'h3C);
    rd_chk(`TCH_OFS_CMP1, 32'h0);
    edit_cmp1(24'h3C, 1'b1);
    chk({31'h0, ctrl_out}, 32'h0);
    chk({31'h0, ind_out}, 32'h0);
    edit_cmp1(24'h28, 1'b0);
    chk({31'h0, ctrl_out}, 32'h1);
    t_kprot();
    t_hold();
    period <= 8'h00;
    repeat (600) @(posedge mclk);
    rd_chk(`TCH_OFS_MEAS, 32'h0);
    chk({31'h0, ctrl_out}, 32'h0);
    t_mode(8'h12, 24'h3C, 24'h28, 1'b0);
    t_mode(8'h16, 24'h3C, 24'h28, 1'b1);
    t_mode(8'h1E, 24'h3C, 24'h00, 1'b1);
    t_rate();
    give_verdict();
  end
endmodule : tch_top_bench
